// *** logic/bst_pkg.sv ***
package bst_pkg;

    // instruction register
    localparam int unsigned IR_W = 4;
    localparam logic [3:0] IR_CLAMP        = 4'h0;
    localparam logic [3:0] IR_EXTEST       = 4'h1;
    localparam logic [3:0] IR_RSVD_A       = 4'h2;
    localparam logic [3:0] IR_RSVD_B       = 4'h3;
    localparam logic [3:0] IR_INTEST       = 4'h4;
    localparam logic [3:0] IR_SAMPLE       = 4'h5;
    localparam logic [3:0] IR_HIGHZ        = 4'h6;
    localparam logic [3:0] IR_HOST_INSTR   = 4'h7;
    localparam logic [3:0] IR_IDCODE       = 4'h8;
    localparam logic [3:0] IR_BYPASS_FIRST = 4'h9;
    localparam logic [3:0] IR_RESET_VAL    = IR_IDCODE;
    localparam logic [3:0] IR_CAPTURE_VAL  = 4'h1;

    // identification register, value is arbitrary, lsb is one as usual
    localparam int unsigned ID_W          = 32;
    localparam logic [31:0] ID_CODE_DFLT  = 32'h0ABC_D001;

    // shared pin positions
    localparam int unsigned NPIN    = 4;
    localparam int unsigned PIN_TCK = 0;
    localparam int unsigned PIN_TMS = 1;
    localparam int unsigned PIN_TDI = 2;
    localparam int unsigned PIN_TDO = 3;

    // digital pins with a boundary cell
    localparam int unsigned BS_CELLS_DFLT = 16;

    // tap controller states
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE,
        ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
        ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } bst_state_t;

    // selected data register
    typedef enum logic [1:0] {
        DR_BYPASS, DR_IDCODE, DR_BOUNDARY, DR_HOST
    } bst_dr_t;

    // boundary cell mode flags toward the pad ring
    typedef struct packed {
        logic drive_pads;
        logic float_pads;
        logic force_core;
    } bst_bs_ctrl_t;

endpackage

// *** logic/bst_tap.sv ***
`timescale 1ns/1ns
`default_nettype none
module bst_tap #(
    parameter int unsigned BS_CELLS = bst_pkg::BS_CELLS_DFLT,
    parameter logic [31:0] ID_CODE  = bst_pkg::ID_CODE_DFLT
) (
    input  wire logic                          i_mclk,
    input  wire logic                          i_rst_n,
    input  wire logic                          i_tck,
    input  wire logic                          i_test_select_pin,
    input  wire logic [bst_pkg::NPIN-1:0]      i_pin,
    output logic      [bst_pkg::NPIN-1:0]      o_pin_out,
    output logic      [bst_pkg::NPIN-1:0]      o_pin_oe,
    input  wire logic [bst_pkg::NPIN-1:0]      i_gpio_out,
    input  wire logic [bst_pkg::NPIN-1:0]      i_gpio_oe,
    output logic      [bst_pkg::NPIN-1:0]      o_gpio_in,
    output logic                               o_tdo,
    output logic                               o_tdo_oe,
    input  wire logic [BS_CELLS-1:0]           i_pad_in,
    input  wire logic [BS_CELLS-1:0]           i_core_out,
    output logic      [BS_CELLS-1:0]           o_bs_upd,
    output bst_pkg::bst_bs_ctrl_t              o_bs_ctrl,
    output logic                               o_hi_select,
    output logic                               o_hi_shift,
    output logic                               o_hi_tdi,
    input  wire logic                          i_hi_tdo
);

    // ---------------- functional clock side: gpio path ----------------
    logic                     msel_meta_q;
    logic                     msel_q;
    logic [bst_pkg::NPIN-1:0] pin_meta_q;
    logic [bst_pkg::NPIN-1:0] pin_sync_q;

    // test select pin into the functional clock
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            msel_meta_q <= 1'b0;
            msel_q      <= 1'b0;
        end else begin
            msel_meta_q <= i_test_select_pin;
            msel_q      <= msel_meta_q;
        end
    end

    // gpio inputs pass two flops before use
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_meta_q <= 4'h0;
            pin_sync_q <= 4'h0;
            o_gpio_in  <= 4'h0;
        end else begin
            pin_meta_q <= i_pin;
            pin_sync_q <= pin_meta_q;
            o_gpio_in  <= msel_q ? 4'h0 : pin_sync_q;
        end
    end

    // gpio drive released while the pins belong to the tap
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pin_out <= 4'h0;
            o_pin_oe  <= 4'h0;
        end else begin
            o_pin_out <= i_gpio_out;
            o_pin_oe  <= (msel_q || i_test_select_pin) ? 4'h0 : i_gpio_oe;
        end
    end

    // ---------------- test clock side ----------------
    logic                  tsel_meta_q;
    logic                  tsel_q;
    bst_pkg::bst_state_t   state_q;
    bst_pkg::bst_state_t   state_d;
    logic [3:0]            ir_sr_q;
    logic [3:0]            ir_q;
    bst_pkg::bst_dr_t      dr_sel;
    logic                  bypass_q;
    logic [31:0]           id_sr_q;
    logic [BS_CELLS-1:0]   bs_sr_q;
    logic                  tms;
    logic                  tdi;
    logic                  tdo_d;
    logic                  oe_clr_n;

    assign tms = i_pin[bst_pkg::PIN_TMS];
    assign tdi = i_pin[bst_pkg::PIN_TDI];

    // test select into the test clock; tck runs only in test mode
    always_ff @(posedge i_tck or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tsel_meta_q <= 1'b0;
            tsel_q      <= 1'b0;
        end else begin
            tsel_meta_q <= i_test_select_pin;
            tsel_q      <= tsel_meta_q;
        end
    end

    // tap next state from tms
    always_comb begin
        state_d = state_q;
        case (state_q)
            bst_pkg::ST_RESET:    state_d = tms ? bst_pkg::ST_RESET    : bst_pkg::ST_IDLE;
            bst_pkg::ST_IDLE:     state_d = tms ? bst_pkg::ST_SEL_DR   : bst_pkg::ST_IDLE;
            bst_pkg::ST_SEL_DR:   state_d = tms ? bst_pkg::ST_SEL_IR   : bst_pkg::ST_CAP_DR;
            bst_pkg::ST_CAP_DR:   state_d = tms ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
            bst_pkg::ST_SHIFT_DR: state_d = tms ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
            bst_pkg::ST_EXIT1_DR: state_d = tms ? bst_pkg::ST_UPD_DR   : bst_pkg::ST_PAUSE_DR;
            bst_pkg::ST_PAUSE_DR: state_d = tms ? bst_pkg::ST_EXIT2_DR : bst_pkg::ST_PAUSE_DR;
            bst_pkg::ST_EXIT2_DR: state_d = tms ? bst_pkg::ST_UPD_DR   : bst_pkg::ST_SHIFT_DR;
            bst_pkg::ST_UPD_DR:   state_d = tms ? bst_pkg::ST_SEL_DR   : bst_pkg::ST_IDLE;
            bst_pkg::ST_SEL_IR:   state_d = tms ? bst_pkg::ST_RESET    : bst_pkg::ST_CAP_IR;
            bst_pkg::ST_CAP_IR:   state_d = tms ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
            bst_pkg::ST_SHIFT_IR: state_d = tms ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
            bst_pkg::ST_EXIT1_IR: state_d = tms ? bst_pkg::ST_UPD_IR   : bst_pkg::ST_PAUSE_IR;
            bst_pkg::ST_PAUSE_IR: state_d = tms ? bst_pkg::ST_EXIT2_IR : bst_pkg::ST_PAUSE_IR;
            bst_pkg::ST_EXIT2_IR: state_d = tms ? bst_pkg::ST_UPD_IR   : bst_pkg::ST_SHIFT_IR;
            bst_pkg::ST_UPD_IR:   state_d = tms ? bst_pkg::ST_SEL_DR   : bst_pkg::ST_IDLE;
            default:              state_d = bst_pkg::ST_RESET;
        endcase
    end

    // tap state, held in reset while test select is low
    always_ff @(posedge i_tck or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= bst_pkg::ST_RESET;
        end else if (!tsel_q) begin
            state_q <= bst_pkg::ST_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // instruction shift and update stages
    always_ff @(posedge i_tck or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ir_sr_q <= bst_pkg::IR_CAPTURE_VAL;
            ir_q    <= bst_pkg::IR_RESET_VAL;
        end else if (state_q == bst_pkg::ST_RESET) begin
            ir_sr_q <= bst_pkg::IR_CAPTURE_VAL;
            ir_q    <= bst_pkg::IR_RESET_VAL;
        end else begin
            case (state_q)
                bst_pkg::ST_CAP_IR:   ir_sr_q <= bst_pkg::IR_CAPTURE_VAL;
                bst_pkg::ST_SHIFT_IR: ir_sr_q <= {tdi, ir_sr_q[3:1]};
                bst_pkg::ST_UPD_IR:   ir_q    <= ir_sr_q;
                default:              ir_sr_q <= ir_sr_q;
            endcase
        end
    end

    // instruction decode to a data register
    always_comb begin
        case (ir_q)
            bst_pkg::IR_EXTEST,
            bst_pkg::IR_INTEST,
            bst_pkg::IR_SAMPLE:     dr_sel = bst_pkg::DR_BOUNDARY;
            bst_pkg::IR_IDCODE:     dr_sel = bst_pkg::DR_IDCODE;
            bst_pkg::IR_HOST_INSTR: dr_sel = bst_pkg::DR_HOST;
            bst_pkg::IR_RSVD_A,
            bst_pkg::IR_RSVD_B:     dr_sel = bst_pkg::DR_BYPASS;
            default:                dr_sel = bst_pkg::DR_BYPASS; // clamp, highz, 9..F
        endcase
    end

    // single bit bypass register
    always_ff @(posedge i_tck or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bypass_q <= 1'b0;
        end else if (state_q == bst_pkg::ST_CAP_DR) begin
            bypass_q <= 1'b0;
        end else if (state_q == bst_pkg::ST_SHIFT_DR) begin
            bypass_q <= tdi;
        end
    end

    // identification register loads the fixed code on capture
    always_ff @(posedge i_tck or negedge i_rst_n) begin
        if (!i_rst_n) begin
            id_sr_q <= 32'h0000_0000;
        end else if (state_q == bst_pkg::ST_CAP_DR && dr_sel == bst_pkg::DR_IDCODE) begin
            id_sr_q <= ID_CODE;
        end else if (state_q == bst_pkg::ST_SHIFT_DR && dr_sel == bst_pkg::DR_IDCODE) begin
            id_sr_q <= {tdi, id_sr_q[31:1]};
        end
    end

    // boundary chain: one cell per digital pin, analog pins have none
    genvar g;
    generate
        for (g = 0; g < BS_CELLS; g++) begin : g_cell
            logic shift_in;
            if (g == BS_CELLS - 1) begin : g_last
                assign shift_in = tdi;
            end else begin : g_mid
                assign shift_in = bs_sr_q[g+1];
            end

            // capture pad or core value, then shift toward tdo
            always_ff @(posedge i_tck or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    bs_sr_q[g] <= 1'b0;
                end else if (dr_sel == bst_pkg::DR_BOUNDARY) begin
                    if (state_q == bst_pkg::ST_CAP_DR) begin
                        bs_sr_q[g] <= (ir_q == bst_pkg::IR_INTEST) ? i_core_out[g]
                                                                    : i_pad_in[g];
                    end else if (state_q == bst_pkg::ST_SHIFT_DR) begin
                        bs_sr_q[g] <= shift_in;
                    end
                end
            end

            // update stage on the falling edge in update-dr
            always_ff @(negedge i_tck or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    o_bs_upd[g] <= 1'b0;
                end else if (state_q == bst_pkg::ST_RESET) begin
                    o_bs_upd[g] <= 1'b0;
                end else if (state_q == bst_pkg::ST_UPD_DR &&
                             dr_sel == bst_pkg::DR_BOUNDARY) begin
                    o_bs_upd[g] <= bs_sr_q[g];
                end
            end
        end
    endgenerate

    // pad ring mode flags follow the active instruction
    always_ff @(negedge i_tck or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_bs_ctrl <= '0;
        end else begin
            o_bs_ctrl.drive_pads <= (ir_q == bst_pkg::IR_EXTEST) ||
                                    (ir_q == bst_pkg::IR_CLAMP);
            o_bs_ctrl.float_pads <= (ir_q == bst_pkg::IR_HIGHZ);
            o_bs_ctrl.force_core <= (ir_q == bst_pkg::IR_INTEST);
        end
    end

    // host instrument link: select, shift and serial data
    always_ff @(negedge i_tck or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_hi_select <= 1'b0;
            o_hi_shift  <= 1'b0;
            o_hi_tdi    <= 1'b0;
        end else begin
            o_hi_select <= (dr_sel == bst_pkg::DR_HOST);
            o_hi_shift  <= (dr_sel == bst_pkg::DR_HOST) && (state_q == bst_pkg::ST_SHIFT_DR);
            o_hi_tdi    <= tdi;
        end
    end

    // serial out selection
    always_comb begin
        tdo_d = bypass_q;
        if (state_q == bst_pkg::ST_SHIFT_IR) begin
            tdo_d = ir_sr_q[0];
        end else begin
            case (dr_sel)
                bst_pkg::DR_IDCODE:   tdo_d = id_sr_q[0];
                bst_pkg::DR_BOUNDARY: tdo_d = bs_sr_q[0];
                bst_pkg::DR_HOST:     tdo_d = i_hi_tdo;
                default:              tdo_d = bypass_q;
            endcase
        end
    end

    // tdo launched on falling tck
    always_ff @(negedge i_tck or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tdo <= 1'b0;
        end else begin
            o_tdo <= tdo_d;
        end
    end

    // enable clear: reset or test select dropped, tck may never run again
    assign oe_clr_n = i_rst_n & i_test_select_pin;

    // tdo driven only while shifting, released at once on deselect
    always_ff @(negedge i_tck or negedge oe_clr_n) begin
        if (!oe_clr_n) begin
            o_tdo_oe <= 1'b0;
        end else begin
            o_tdo_oe <= tsel_q && ((state_q == bst_pkg::ST_SHIFT_IR) ||
                                   (state_q == bst_pkg::ST_SHIFT_DR));
        end
    end

endmodule
`default_nettype wire

// *** verification/bst_tap_checker.sv ***
`timescale 1ns/1ns
`default_nettype none
module bst_tap_checker #(
    parameter int unsigned BS_CELLS = bst_pkg::BS_CELLS_DFLT
) (
    input wire logic                     i_mclk,
    input wire logic                     i_rst_n,
    input wire logic                     i_tck,
    input wire logic                     i_test_select_pin,
    input wire logic [bst_pkg::NPIN-1:0] i_gpio_out,
    input wire logic [bst_pkg::NPIN-1:0] i_gpio_oe,
    input wire logic [bst_pkg::NPIN-1:0] o_pin_out,
    input wire logic [bst_pkg::NPIN-1:0] o_pin_oe,
    input wire logic                     o_tdo,
    input wire logic                     o_tdo_oe,
    input wire logic [BS_CELLS-1:0]      o_bs_upd,
    input wire bst_pkg::bst_bs_ctrl_t    o_bs_ctrl,
    input wire logic                     o_hi_select,
    input wire logic                     o_hi_shift
);
    logic [BS_CELLS+5:0] rise_q;
    logic [2:0]          low_q;
    // tck-side outputs as they stood before each rising edge
    always_ff @(posedge i_tck or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rise_q <= '0;
        end else begin
            rise_q <= {o_bs_upd, o_bs_ctrl, o_hi_select, o_tdo_oe, o_tdo};
        end
    end
    // mclk cycles since test select went low, saturating
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            low_q <= '0;
        end else if (i_test_select_pin) begin
            low_q <= '0;
        end else if (low_q != 3'h7) begin
            low_q <= low_q + 3'h1;
        end
    end
    a_tdo_on_fall: assert property (@(negedge i_tck) disable iff (!i_rst_n)
        o_tdo == rise_q[0]) else $error("tdo moved on rising tck");
    a_oe_on_fall: assert property (@(negedge i_tck) disable iff (!i_rst_n)
        o_tdo_oe == rise_q[1]) else $error("tdo enable moved on rising tck");
    a_ctrl_on_fall: assert property (@(negedge i_tck) disable iff (!i_rst_n)
        {o_bs_ctrl, o_hi_select} == rise_q[5:2]) else $error("mode flags moved on rising tck");
    a_upd_on_fall: assert property (@(negedge i_tck) disable iff (!i_rst_n)
        o_bs_upd == rise_q[BS_CELLS+5:6]) else $error("update stage moved on rising tck");
    a_oe_needs_sel: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !i_test_select_pin |-> !o_tdo_oe) else $error("tdo driven without test select");
    a_gpio_oe_masked: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_test_select_pin |-> o_pin_oe == '0) else $error("gpio drives in test mode");
    a_gpio_follows: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        low_q == 3'h7 |-> o_pin_oe == $past(i_gpio_oe) && o_pin_out == $past(i_gpio_out))
        else $error("gpio drive not passed through");
    a_hi_shift_sel: assert property (@(posedge i_tck) disable iff (!i_rst_n)
        o_hi_shift |-> o_hi_select) else $error("instrument shift without select");
    c_shift: cover property (@(posedge i_tck) o_tdo_oe);
    c_hi_shift: cover property (@(posedge i_tck) o_hi_shift);
    c_float: cover property (@(posedge i_tck) o_bs_ctrl.float_pads);
endmodule
bind bst_tap bst_tap_checker #(.BS_CELLS(BS_CELLS)) bst_tap_checker_i (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_tck(i_tck), .i_test_select_pin(i_test_select_pin),
    .i_gpio_out(i_gpio_out), .i_gpio_oe(i_gpio_oe), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
    .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .o_bs_upd(o_bs_upd), .o_bs_ctrl(o_bs_ctrl),
    .o_hi_select(o_hi_select), .o_hi_shift(o_hi_shift));
`default_nettype wire

// *** verification/bst_jtag_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module bst_jtag_host (
    output logic      o_tck,
    output logic      o_tms,
    output logic      o_tdi,
    input  wire logic i_tdo_pin,
    input  wire logic i_tdo_oe
);
    // idle levels, tck still between frames
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b0;
    end
    // one tck per step, four wires plus the tdo enable
    task automatic scan(input int n, input logic [63:0] tms_v, input logic [63:0] tdi_v,
                        output logic [63:0] tdo_v, output logic [63:0] oe_v);
        tdo_v = '0;
        oe_v = '0;
        for (int i = 0; i < n; i++) begin
            #40;
            o_tms = tms_v[i]; // set after falling edge, steady at rising
            o_tdi = tdi_v[i];
            #40 o_tck = 1'b1;
            tdo_v[i] = i_tdo_pin; // taken at rising edge
            oe_v[i] = i_tdo_oe;
            #80 o_tck = 1'b0;
        end
        #40 o_tdi = ~o_tdi; // released data line shows no stale value
    endtask
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam int unsigned NB = 8;
    localparam logic [31:0] ID = 32'h1357_9BDF; // arbitrary identification value
    logic                  mclk = 1'b0;
    logic                  rst_n = 1'b0;
    logic                  sel = 1'b0;
    logic                  tog = 1'b0;
    logic                  hi_q = 1'b0;
    logic [3:0]            gpio_out = 4'h0;
    logic [3:0]            gpio_oe = 4'h0;
    logic [NB-1:0]         pad_in = '0;
    logic [NB-1:0]         core_out = '0;
    logic [3:0]            pin_out, pin_oe, gpio_in, pin, c, cap;
    logic                  tdo, tdo_oe, hi_sel, hi_shift, hi_tdi;
    logic [NB-1:0]         bs_upd;
    bst_pkg::bst_bs_ctrl_t bs_ctrl;
    wire logic             tck, tms, tdi;
    logic [31:0]           seed = 32'hBD89;
    logic [63:0]           d, got;
    int                    miscompares = 0;
    int                    samples_checked = 0;
    // clocks, toggling level on the released tdo pin, instrument shift stage
    always #25 mclk = ~mclk;
    always @(posedge mclk) tog <= ~tog;
    always @(posedge tck)
        if (hi_shift) hi_q <= hi_tdi;
    // shared pins: tap, gpio or released
    assign pin[0] = tck;
    assign pin[1] = pin_oe[1] ? pin_out[1] : tms;
    assign pin[2] = pin_oe[2] ? pin_out[2] : tdi;
    assign pin[3] = tdo_oe ? tdo : (pin_oe[3] ? pin_out[3] : tog);
    bst_jtag_host bst_jtag_host_i (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo_pin(pin[3]),
        .i_tdo_oe(tdo_oe));
    bst_tap #(.BS_CELLS(NB), .ID_CODE(ID)) bst_tap_i (
        .i_mclk(mclk), .i_rst_n(rst_n), .i_tck(tck), .i_test_select_pin(sel), .i_pin(pin),
        .o_pin_out(pin_out), .o_pin_oe(pin_oe), .i_gpio_out(gpio_out), .i_gpio_oe(gpio_oe),
        .o_gpio_in(gpio_in), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_pad_in(pad_in),
        .i_core_out(core_out), .o_bs_upd(bs_upd), .o_bs_ctrl(bs_ctrl), .o_hi_select(hi_sel),
        .o_hi_shift(hi_shift), .o_hi_tdi(hi_tdi), .i_hi_tdo(hi_q));
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    // one-bit path: a zero first, then the data one step late
    function automatic logic [63:0] one_late(input logic [63:0] v, input int n);
        return (v << 1) & ((64'd1 << n) - 64'd1);
    endfunction
    task automatic check(input logic [63:0] g, input logic [63:0] e);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("Error at %0t: got %0h expected %0h", $time, g, e);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic ir_scan(input logic [3:0] code, output logic [3:0] cp);
        logic [63:0] t, o;
        bst_jtag_host_i.scan(10, 64'h183, {56'h0, code, 4'h0}, t, o);
        cp = t[7:4];
    endtask
    task automatic dr_scan(input int n, input logic [63:0] v, output logic [63:0] r);
        logic [63:0] t, o, m;
        m = (64'd1 << n) - 64'd1;
        bst_jtag_host_i.scan(n + 5, 64'd1 | (64'd3 << (n + 2)), v << 3, t, o);
        r = (t >> 3) & m;
        check(o, m << 3);
    endtask
    // cut a hang short
    initial begin
        #2000000;
        miscompares++;
        close_out();
    end
    // main sequence
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 20; i++) begin
            @(posedge mclk);
            seed = xs(seed);
            d = {gpio_oe, gpio_out};
            {gpio_oe, gpio_out} <= seed[7:0];
            #1 check({pin_oe, pin_out}, d);
        end
        @(posedge mclk);
        gpio_oe <= 4'h0;
        repeat (5) @(posedge mclk);
        #1 check(gpio_in[2:1], {tdi, tms});
        $display("gpio test done");
        @(posedge mclk);
        sel <= 1'b1;
        repeat (4) @(posedge mclk);
        #1 check({pin_oe, gpio_in}, 8'h0);
        bst_jtag_host_i.scan(8, 64'h7F, 64'h0, got, d);
        dr_scan(32, 64'h0, got);
        check(got, ID);
        for (int k = 0; k < 16; k++) begin
            c = k[3:0];
            @(posedge mclk);
            seed = xs(seed);
            pad_in <= seed[7:0];
            core_out <= seed[15:8];
            d = {32'h0, xs(seed)};
            ir_scan(c, cap);
            check(cap, 4'h1);
            case (c)
                4'h8: begin
                    dr_scan(32, d, got);
                    check(got, ID);
                end
                4'h1, 4'h4, 4'h5: begin
                    dr_scan(2 * NB, d, got);
                    check(got[NB-1:0], (c == 4'h4) ? core_out : pad_in);
                    check(got >> NB, d[NB-1:0]);
                    check(bs_upd, d[2*NB-1:NB]);
                end
                4'h7: begin
                    dr_scan(8, d, got);
                    check(got & 64'hFE, (d << 2) & 64'hFE);
                end
                default: begin
                    dr_scan(8, d, got);
                    check(got, one_late(d, 8));
                end
            endcase
            check({bs_ctrl, hi_sel}, {c == 4'h0 || c == 4'h1, c == 4'h6, c == 4'h4, c == 4'h7});
        end
        $display("instruction test done");
        bst_jtag_host_i.scan(3, 64'h1, 64'h0, got, d);
        check(tdo_oe, 1'b1);
        @(posedge mclk);
        sel <= 1'b0;
        #1 check(tdo_oe, 1'b0);
        repeat (4) @(posedge mclk);
        sel <= 1'b1;
        bst_jtag_host_i.scan(8, 64'h7F, 64'h0, got, d);
        dr_scan(32, 64'h0, got);
        check(got, ID);
        $display("abort test done");
        close_out();
    end
endmodule
`default_nettype wire
